//--- hdl/mcc_defs.svh
// Constants for the serial slave command checker: addresses, codes, fields, timing
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH
// Register addresses
`define MCC_REG_RUN_CTRL 16'h0001
`define MCC_REG_SPEED_REF 16'h0002
`define MCC_REG_BCAST_LAST 16'h0002
`define MCC_REG_COMMIT_NV 16'h0900
`define MCC_REG_COMMIT_RAM 16'h0910
`define MCC_COMMIT_VALUE 16'h0000
// Slave addressing
`define MCC_BCAST_ADDR 8'h00
// Function codes
`define MCC_FC_READ 8'h03
`define MCC_FC_DIAG 8'h08
`define MCC_FC_WRITE 8'h10
// Exception codes
`define MCC_EX_NONE 8'h00
`define MCC_EX_FUNC 8'h01
`define MCC_EX_ADDR 8'h02
`define MCC_EX_QTY 8'h03
`define MCC_EX_DATA 8'h21
`define MCC_EX_MODE 8'h22
`define MCC_EX_UV 8'h23
`define MCC_EX_BUSY 8'h24
// Operation word bit positions
`define MCC_BIT_RUN 0
`define MCC_BIT_REV 1
`define MCC_BIT_EXTF 4
`define MCC_BIT_FRST 5
`define MCC_BIT_MI5 12
`define MCC_BIT_MI6 13
`define MCC_BIT_MI7 14
// Bits driven from the broadcast word, the rest come from the local node
`define MCC_BCAST_MASK 16'h7033
`define MCC_OP_RESET 16'h0000
`define MCC_SPEED_RESET 16'h0000
// Speed reference full scale, 30000 counts
`define MCC_SPEED_FULL 16'h7530
// Word count limits
`define MCC_WORDS_MIN 8'h01
`define MCC_WORDS_MAX 8'h10
// Input seven function value that selects the loopback self-test
`define MCC_TEST_SEL 8'h43
// Self-test bytes, sent from the top byte down
`define MCC_TEST_PATTERN 32'h55AA0FF0
`define MCC_TEST_BYTES 3'h4
// Timing
`define MCC_CLK_NS 20
`define MCC_TEST_TIMEOUT_NS 1000000
`endif

//--- hdl/mcc_pkg.sv
// Types for the serial slave command checker
package mcc_pkg;
	// Operating mode, Gray along strap -> test -> fail
	typedef enum logic [1:0] {
		MCC_MODE_STRAP = 2'h0,
		MCC_MODE_TEST = 2'h1,
		MCC_MODE_FAIL = 2'h3,
		MCC_MODE_NORMAL = 2'h2
	} mcc_mode_t;
	// Self-test sequencer, Gray along idle -> send -> wait -> done
	typedef enum logic [1:0] {
		MCC_LT_IDLE = 2'h0,
		MCC_LT_SEND = 2'h1,
		MCC_LT_WAIT = 2'h3,
		MCC_LT_DONE = 2'h2
	} mcc_lt_state_t;
	typedef logic [15:0][15:0] mcc_words_t;
endpackage : mcc_pkg

//--- hdl/mcc_loopback_test.sv
// Loopback self-test: sends a byte pattern and checks each echo
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_loopback_test #(
	parameter int TIMEOUT_CYCLES = 50000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic done,
	output logic fail
);
	typedef struct packed {
		mcc_pkg::mcc_lt_state_t state;
		logic [2:0] idx;
		logic [16:0] tmr;
		logic [7:0] byte_out;
		logic done;
		logic fail;
	} mcc_lt_reg_t;

	mcc_lt_reg_t st;
	mcc_lt_reg_t next_st;
	logic [31:0] pattern;

	assign pattern = `MCC_TEST_PATTERN;
	assign tx_valid = (st.state == mcc_pkg::MCC_LT_SEND);
	assign tx_data = st.byte_out;
	assign done = st.done;
	assign fail = st.fail;

	// Sequencer: one byte out, wait for it back, then the next
	always_comb begin
		next_st = st;
		unique case (st.state)
			mcc_pkg::MCC_LT_IDLE: begin
				if (start) begin
					next_st.state = mcc_pkg::MCC_LT_SEND;
					next_st.idx = 3'h0;
					next_st.byte_out = pattern[31:24];
				end
			end
			mcc_pkg::MCC_LT_SEND: begin
				if (tx_ready) begin
					next_st.state = mcc_pkg::MCC_LT_WAIT;
					next_st.tmr = 17'h00000;
				end
			end
			mcc_pkg::MCC_LT_WAIT: begin
				next_st.tmr = st.tmr + 17'h00001;
				if (rx_valid) begin
					// Any mismatch fails at once; no retry, the wiring is at fault
					if (rx_data != st.byte_out) begin
						next_st.fail = 1'b1;
						next_st.done = 1'b1;
						next_st.state = mcc_pkg::MCC_LT_DONE;
					end else if (st.idx == `MCC_TEST_BYTES - 3'h1) begin
						next_st.done = 1'b1;
						next_st.state = mcc_pkg::MCC_LT_DONE;
					end else begin
						next_st.idx = st.idx + 3'h1;
						next_st.byte_out = pattern[8'(5'd23 - 5'(st.idx) * 5'd8) -: 8];
						next_st.state = mcc_pkg::MCC_LT_SEND;
					end
				end else if (st.tmr >= 17'(TIMEOUT_CYCLES)) begin
					// No echo at all: open loop counts as a failure
					next_st.fail = 1'b1;
					next_st.done = 1'b1;
					next_st.state = mcc_pkg::MCC_LT_DONE;
				end
			end
			mcc_pkg::MCC_LT_DONE: begin
				next_st.state = mcc_pkg::MCC_LT_DONE;
			end
		endcase
	end

	// State register, frozen while ce is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end
endmodule : mcc_loopback_test

//--- hdl/mcc_command_checker.sv
// Serial slave command checker: request validation, broadcast control, parameter staging
//
// Overview of operation
// - Broadcast word bit 0 is run/stop, bit 1 is reverse/forward.
// - Broadcast bit 4 raises external fault, bit 5 issues fault reset.
// - Broadcast bits C, D, E act as multi-function inputs five, six, seven.
// - Broadcast registers writable; speed reference 30000 means full reference.
// - Operation bits not carried by broadcast keep following local node signals.
// - Written parameters wait in a staging area until committed.
// - Writing zero to COMMIT_PARAMS_NONVOLATILE commits to RAM and non-volatile; COMMIT_PARAMS_RAM_ONLY RAM only.
// - Commit registers are write-only; reading them returns code 02H.
// - Function codes other than 03H, 08H, 10H return code 01H.
// - Unknown register, or broadcast start beyond 0000H-BROADCAST_SPEED_REFERENCE, returns 02H.
// - Word count outside 1..16 or byte count not twice it returns 03H.
// - Written value beyond limits or invalid setting returns 21H.
// - Parameter write or commit while running, or write to read-only, returns 22H.
// - Under non-volatile fault, writes to non-exempt parameters return 22H.
// - Parameter write or commit during main undervoltage returns 23H.
// - Parameter write while parameters are being processed returns 24H.
// - Frames with overrun, framing, parity or CRC errors are dropped silently.
// - Frames for another slave address are dropped silently.
// - Frames with an over-long gap or bad length are dropped silently.
// - Address zero writes execute on every slave and never get a reply.
// - Input seven set to 67 at power-up starts the loopback self-test.
// - Self-test failure raises alarm, fault output, drops ready; pass shows speed.
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_command_checker #(
	parameter int TEST_TIMEOUT_CYCLES = `MCC_TEST_TIMEOUT_NS / `MCC_CLK_NS
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] node_address,
	input wire logic [7:0] input_seven_function_select,
	input wire logic frame_word_valid,
	input wire logic [15:0] frame_word_data,
	input wire logic frame_done,
	input wire logic [7:0] frame_slave_addr,
	input wire logic [7:0] frame_func,
	input wire logic [15:0] frame_start_addr,
	input wire logic [7:0] frame_word_count,
	input wire logic [7:0] frame_byte_count,
	input wire logic err_overrun,
	input wire logic err_framing,
	input wire logic err_parity,
	input wire logic err_crc,
	input wire logic err_gap,
	input wire logic err_length,
	input wire logic reg_exists,
	input wire logic reg_read_only,
	input wire logic param_in_limits,
	input wire logic param_setting_valid,
	input wire logic param_nv_exempt,
	input wire logic drive_running,
	input wire logic nonvolatile_memory_fault,
	input wire logic main_undervoltage_alarm,
	input wire logic param_processing,
	input wire logic [15:0] local_op_word,
	output logic resp_valid,
	output logic resp_exception,
	output logic [7:0] resp_func,
	output logic [7:0] resp_code,
	output logic read_req,
	output logic [15:0] op_word_eff,
	output logic run_cmd,
	output logic reverse_cmd,
	output logic ext_fault_cmd,
	output logic fault_reset_cmd,
	output logic multi_input_five,
	output logic multi_input_six,
	output logic multi_input_seven,
	output logic [15:0] speed_ref,
	output logic commit_ram_pulse,
	output logic commit_nv_pulse,
	output logic [15:0] stage_base,
	output logic [4:0] stage_count,
	input wire logic [3:0] stage_index,
	output logic [15:0] stage_data,
	output logic test_mode,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic comm_error_alarm,
	output logic fault_output,
	output logic operation_ready,
	output logic show_speed_ref
);
	typedef struct packed {
		mcc_pkg::mcc_mode_t mode;
		logic test_start;
		mcc_pkg::mcc_words_t rx_buf;
		logic [4:0] rx_cnt;
		mcc_pkg::mcc_words_t stage;
		logic [15:0] stage_base;
		logic [4:0] stage_cnt;
		logic [15:0] op_word;
		logic [15:0] op_eff;
		logic [15:0] speed;
		logic resp_valid;
		logic resp_exc;
		logic [7:0] resp_func;
		logic [7:0] resp_code;
		logic read_req;
		logic commit_ram;
		logic commit_nv;
	} mcc_reg_t;

	mcc_reg_t st;
	mcc_reg_t next_st;
	logic lt_done;
	logic lt_fail;
	logic drop;
	logic bcast;
	logic is_commit;
	logic is_ctrl;
	logic speed_over;
	logic [15:0] last_addr;
	logic [7:0] code;

	// Self-test owns the serial line only in test mode
	mcc_loopback_test #(
		.TIMEOUT_CYCLES(TEST_TIMEOUT_CYCLES)
	) u_loopback (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.start(st.test_start),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.done(lt_done),
		.fail(lt_fail)
	);

	// Frame screening: any line error, wrong node or bad timing drops the frame
	assign drop = err_overrun | err_framing | err_parity | err_crc
		| (err_gap | err_length)
		| ((frame_slave_addr != node_address) && (frame_slave_addr != `MCC_BCAST_ADDR));
	assign bcast = (frame_slave_addr == `MCC_BCAST_ADDR);
	assign last_addr = frame_start_addr + {8'h00, frame_word_count} - 16'h0001;
	assign is_commit = (frame_start_addr == `MCC_REG_COMMIT_NV)
		|| (frame_start_addr == `MCC_REG_COMMIT_RAM);
	// Start checked too, so a block wrapping past FFFFH is not taken as control
	assign is_ctrl = (frame_start_addr <= `MCC_REG_BCAST_LAST) && (last_addr <= `MCC_REG_BCAST_LAST);

	// Speed words above full scale are a limit error
	always_comb begin
		speed_over = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if ((5'(i) < frame_word_count[4:0])
				&& (frame_start_addr + 16'(i) == `MCC_REG_SPEED_REF)
				&& (st.rx_buf[i] > `MCC_SPEED_FULL)) begin
				speed_over = 1'b1;
			end
		end
	end

	// Exception code in priority order; zero means accept
	always_comb begin
		code = `MCC_EX_NONE;
		if ((frame_func != `MCC_FC_READ) && (frame_func != `MCC_FC_DIAG)
			&& (frame_func != `MCC_FC_WRITE)) begin
			code = `MCC_EX_FUNC;
		end else if (frame_func == `MCC_FC_DIAG) begin
			code = `MCC_EX_NONE;
		end else if ((frame_word_count < `MCC_WORDS_MIN) || (frame_word_count > `MCC_WORDS_MAX)) begin
			code = `MCC_EX_QTY;
		end else if ((frame_func == `MCC_FC_WRITE)
			&& ({1'b0, frame_byte_count} != {frame_word_count, 1'b0})) begin
			code = `MCC_EX_QTY;
		end else if (bcast && ((frame_func != `MCC_FC_WRITE) || !is_ctrl)) begin
			code = `MCC_EX_ADDR;
		end else if ((frame_func == `MCC_FC_READ) && is_commit) begin
			code = `MCC_EX_ADDR;
		end else if (!bcast && !is_commit && !is_ctrl && !reg_exists) begin
			code = `MCC_EX_ADDR;
		end else if (frame_func == `MCC_FC_READ) begin
			code = `MCC_EX_NONE;
		end else if (is_commit) begin
			// Commit takes exactly one word holding zero
			if (frame_word_count != `MCC_WORDS_MIN) begin
				code = `MCC_EX_QTY;
			end else if (drive_running) begin
				code = `MCC_EX_MODE;
			end else if (main_undervoltage_alarm) begin
				code = `MCC_EX_UV;
			end else if (st.rx_buf[0] != `MCC_COMMIT_VALUE) begin
				code = `MCC_EX_DATA;
			end
		end else if (is_ctrl) begin
			if (speed_over) begin
				code = `MCC_EX_DATA;
			end
		end else if (reg_read_only) begin
			code = `MCC_EX_MODE;
		end else if (!param_in_limits || !param_setting_valid) begin
			code = `MCC_EX_DATA;
		end else if (drive_running) begin
			code = `MCC_EX_MODE;
		end else if (main_undervoltage_alarm) begin
			code = `MCC_EX_UV;
		end else if (nonvolatile_memory_fault && !param_nv_exempt) begin
			code = `MCC_EX_MODE;
		end else if (param_processing) begin
			code = `MCC_EX_BUSY;
		end
	end

	// Next-state logic for mode, buffers, control words and replies
	always_comb begin
		next_st = st;
		next_st.test_start = 1'b0;
		next_st.resp_valid = 1'b0;
		next_st.read_req = 1'b0;
		next_st.commit_ram = 1'b0;
		next_st.commit_nv = 1'b0;
		// Local signals fill every bit the broadcast word does not define
		next_st.op_eff = (st.op_word & `MCC_BCAST_MASK) | (local_op_word & ~`MCC_BCAST_MASK);
		unique case (st.mode)
			mcc_pkg::MCC_MODE_STRAP: begin
				// Strap sampled once after reset release, never again
				if (input_seven_function_select == `MCC_TEST_SEL) begin
					next_st.mode = mcc_pkg::MCC_MODE_TEST;
					next_st.test_start = 1'b1;
				end else begin
					next_st.mode = mcc_pkg::MCC_MODE_NORMAL;
				end
			end
			mcc_pkg::MCC_MODE_TEST: begin
				if (lt_done && lt_fail) begin
					next_st.mode = mcc_pkg::MCC_MODE_FAIL;
				end
			end
			mcc_pkg::MCC_MODE_FAIL: begin
				next_st.mode = mcc_pkg::MCC_MODE_FAIL;
			end
			mcc_pkg::MCC_MODE_NORMAL: begin
				// Collect data words ahead of the frame verdict
				if (frame_word_valid && (st.rx_cnt < 5'h10)) begin
					next_st.rx_buf[st.rx_cnt[3:0]] = frame_word_data;
					next_st.rx_cnt = st.rx_cnt + 5'h01;
				end
				if (frame_done) begin
					next_st.rx_cnt = 5'h00;
					if (!drop) begin
						// Broadcasts never reply, whatever the outcome
						next_st.resp_valid = !bcast;
						next_st.resp_exc = (code != `MCC_EX_NONE);
						next_st.resp_func = frame_func;
						next_st.resp_code = code;
						if (code == `MCC_EX_NONE) begin
							if (frame_func == `MCC_FC_READ) begin
								next_st.read_req = 1'b1;
							end else if ((frame_func == `MCC_FC_WRITE) && is_commit) begin
								// Commit hands the staged block over and empties staging
								next_st.commit_nv = (frame_start_addr == `MCC_REG_COMMIT_NV);
								next_st.commit_ram = (frame_start_addr == `MCC_REG_COMMIT_RAM);
								next_st.stage_cnt = 5'h00;
							end else if ((frame_func == `MCC_FC_WRITE) && is_ctrl) begin
								for (int i = 0; i < 16; i++) begin
									if (5'(i) < frame_word_count[4:0]) begin
										if (frame_start_addr + 16'(i) == `MCC_REG_RUN_CTRL) begin
											next_st.op_word = st.rx_buf[i];
										end
										if (frame_start_addr + 16'(i) == `MCC_REG_SPEED_REF) begin
											next_st.speed = st.rx_buf[i];
										end
									end
								end
							end else if (frame_func == `MCC_FC_WRITE) begin
								// Parameters wait here; the drive sees them only on commit
								next_st.stage = st.rx_buf;
								next_st.stage_base = frame_start_addr;
								next_st.stage_cnt = frame_word_count[4:0];
							end
						end
					end
				end
			end
		endcase
	end

	// All state in one register, frozen while ce is low
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '0;
			st.mode <= mcc_pkg::MCC_MODE_STRAP;
			st.op_word <= `MCC_OP_RESET;
			st.op_eff <= `MCC_OP_RESET;
			st.speed <= `MCC_SPEED_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Replies and strobes
	assign resp_valid = st.resp_valid;
	assign resp_exception = st.resp_exc;
	assign resp_func = st.resp_func;
	assign resp_code = st.resp_code;
	assign read_req = st.read_req;
	assign commit_ram_pulse = st.commit_ram;
	assign commit_nv_pulse = st.commit_nv;
	assign stage_base = st.stage_base;
	assign stage_count = st.stage_cnt;
	assign stage_data = st.stage[stage_index];

	// Operation word fields; the multi-function input bits are mapped by the input selection settings downstream
	assign op_word_eff = st.op_eff;
	assign run_cmd = st.op_eff[`MCC_BIT_RUN];
	assign reverse_cmd = st.op_eff[`MCC_BIT_REV];
	assign ext_fault_cmd = st.op_eff[`MCC_BIT_EXTF];
	assign fault_reset_cmd = st.op_eff[`MCC_BIT_FRST];
	assign multi_input_five = st.op_eff[`MCC_BIT_MI5];
	assign multi_input_six = st.op_eff[`MCC_BIT_MI6];
	assign multi_input_seven = st.op_eff[`MCC_BIT_MI7];
	assign speed_ref = st.speed;

	// Self-test status; ready stays low until the strap is read
	assign test_mode = (st.mode == mcc_pkg::MCC_MODE_TEST) || (st.mode == mcc_pkg::MCC_MODE_FAIL);
	assign comm_error_alarm = (st.mode == mcc_pkg::MCC_MODE_FAIL);
	assign fault_output = (st.mode == mcc_pkg::MCC_MODE_FAIL);
	assign operation_ready = (st.mode == mcc_pkg::MCC_MODE_NORMAL)
		|| (st.mode == mcc_pkg::MCC_MODE_TEST);
	assign show_speed_ref = (st.mode == mcc_pkg::MCC_MODE_TEST) && lt_done && !lt_fail;
endmodule : mcc_command_checker

//--- sim/mcc_command_checker_chk.sv
// Port-level assertions for the command checker
`timescale 1ns/1ps
module mcc_command_checker_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] node_address,
	input wire logic frame_done,
	input wire logic [7:0] frame_slave_addr,
	input wire logic [7:0] frame_func,
	input wire logic err_overrun,
	input wire logic err_framing,
	input wire logic err_parity,
	input wire logic err_crc,
	input wire logic err_gap,
	input wire logic err_length,
	input wire logic [15:0] local_op_word,
	input wire logic resp_valid,
	input wire logic resp_exception,
	input wire logic [7:0] resp_code,
	input wire logic [15:0] op_word_eff,
	input wire logic run_cmd,
	input wire logic reverse_cmd,
	input wire logic multi_input_seven,
	input wire logic commit_nv_pulse,
	input wire logic test_mode,
	input wire logic comm_error_alarm,
	input wire logic fault_output,
	input wire logic operation_ready
);
	logic bad_frame;
	logic taken;
	// Any receive fault drops the frame; only normal mode judges frames
	assign bad_frame = err_overrun | err_framing | err_parity | err_crc | err_gap | err_length;
	assign taken = ce & frame_done & operation_ready & !test_mode;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// Silent cases: damaged frames and frames for other nodes or broadcast
	property p_drop;
		ce && frame_done && bad_frame |=> !resp_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("reply to a damaged frame");
	property p_foreign;
		ce && frame_done && frame_slave_addr != node_address |=> !resp_valid;
	endproperty
	a_foreign: assert property (p_foreign) else $error("reply to a foreign frame");
	// Unknown function code answered one cycle later with code 01
	property p_func;
		taken && !bad_frame && frame_slave_addr == node_address
			&& !(frame_func inside {8'h03, 8'h08, 8'h10})
			|=> resp_valid && resp_exception && resp_code == 8'h01;
	endproperty
	a_func: assert property (p_func) else $error("bad function not refused");
	// Command outputs follow the effective operation word
	property p_dir;
		{reverse_cmd, run_cmd} == op_word_eff[1:0];
	endproperty
	a_dir: assert property (p_dir) else $error("run or direction mismatch");
	property p_mi7;
		multi_input_seven == op_word_eff[14];
	endproperty
	a_mi7: assert property (p_mi7) else $error("input seven mismatch");
	// Bits outside the broadcast set track the local word one cycle late
	property p_local;
		ce && $past(ce) && !$past(rst)
			|-> ((op_word_eff ^ $past(local_op_word)) & 16'h8FCC) == 16'h0000;
	endproperty
	a_local: assert property (p_local) else $error("local bits not followed");
	property p_fail;
		comm_error_alarm |-> fault_output && !operation_ready;
	endproperty
	a_fail: assert property (p_fail) else $error("self-test failure outputs wrong");
	property p_commit;
		commit_nv_pulse |-> resp_valid && !resp_exception ##1 !commit_nv_pulse;
	endproperty
	a_commit: assert property (p_commit) else $error("commit without good reply");
endmodule : mcc_command_checker_chk
bind mcc_command_checker mcc_command_checker_chk i_mcc_command_checker_chk (.*);

//--- sim/mcc_plc_loop.sv
// Far-side loop wiring that echoes each self-test byte back
`timescale 1ns/1ps
module mcc_plc_loop (
	input wire logic sys_clk,
	input wire logic slow,
	input wire logic corrupt,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	logic [7:0] held = 8'h00;
	logic busy = 1'b0;
	int wait_n = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// One byte in flight; idle data toggles so a stale byte never passes
	always @(posedge sys_clk) begin
		tx_ready <= tx_valid && !busy && !tx_ready;
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
		if (tx_valid && tx_ready) begin
			held <= tx_data;
			busy <= 1'b1;
			wait_n <= slow ? 20 : 1;
		end else if (busy && wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else if (busy) begin
			busy <= 1'b0;
			rx_valid <= 1'b1;
			rx_data <= corrupt ? ~held : held;
		end
	end
endmodule : mcc_plc_loop

//--- sim/mcc_command_checker_tb_top.sv
// Self-checking bench for the command checker
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_command_checker_tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] node_address = 8'h11;
	logic [3:0] stage_index = 4'h0;
	logic [7:0] input_seven_function_select = 8'h00;
	logic frame_word_valid = 1'b0;
	logic frame_done = 1'b0;
	logic [15:0] frame_word_data, frame_start_addr, local_op_word;
	logic [7:0] frame_slave_addr, frame_func, frame_word_count, frame_byte_count;
	logic err_overrun, err_framing, err_parity, err_crc, err_gap, err_length;
	logic reg_exists, reg_read_only, param_in_limits, param_setting_valid, param_nv_exempt;
	logic drive_running, main_undervoltage_alarm, nonvolatile_memory_fault, param_processing;
	logic resp_valid, resp_exception, read_req, run_cmd, reverse_cmd, ext_fault_cmd;
	logic fault_reset_cmd, multi_input_five, multi_input_six, multi_input_seven;
	logic commit_ram_pulse, commit_nv_pulse, test_mode, tx_valid, tx_ready, rx_valid;
	logic comm_error_alarm, fault_output, operation_ready, show_speed_ref, slow, corrupt;
	logic [7:0] resp_func, resp_code, tx_data, rx_data;
	logic [15:0] op_word_eff, speed_ref, stage_base, stage_data;
	logic [4:0] stage_count;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	// Short self-test timeout keeps the loopback runs brief
	mcc_command_checker #(.TEST_TIMEOUT_CYCLES(50)) i_mcc_command_checker (.*);
	mcc_plc_loop i_mcc_plc_loop (.*);
	always #10 sys_clk = ~sys_clk;
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	// Hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Status levels: exempt, read-only, limits ok, valid, run, undervoltage, nv fault, busy
	task automatic set_st(input logic [7:0] s);
		{param_nv_exempt, reg_read_only, param_in_limits, param_setting_valid} = s[7:4];
		{drive_running, main_undervoltage_alarm, nonvolatile_memory_fault, param_processing} = s[3:0];
	endtask : set_st
	task automatic set_err(input logic [5:0] e);
		{err_overrun, err_framing, err_parity, err_crc, err_gap, err_length} = e;
	endtask : set_err
	task automatic do_reset;
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : do_reset
	// One frame; ex[8] says a reply is due, ex[7:0] its code
	task automatic req(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] sta,
		input logic [7:0] wc, input logic [7:0] bc, input logic [15:0] w, input logic [8:0] ex);
		if (fc == 8'h10) begin
			frame_word_valid = 1'b1;
			frame_word_data = w;
			@(posedge sys_clk) #1;
			frame_word_valid = 1'b0;
		end
		{frame_slave_addr, frame_func, frame_start_addr} = {sa, fc, sta};
		{frame_word_count, frame_byte_count} = {wc, bc};
		frame_done = 1'b1;
		@(posedge sys_clk) #1;
		frame_done = 1'b0;
		chk(resp_valid, ex[8]);
		if (ex[8]) begin
			chk(resp_code, ex[7:0]);
			chk(resp_exception, ex[7:0] != 8'h00);
			chk(resp_func, fc);
		end
	endtask : req
	task automatic wr(input logic [15:0] sta, input logic [15:0] w, input logic [8:0] ex);
		req(8'h11, 8'h10, sta, 8'h01, 8'h02, w, ex);
	endtask : wr
	task automatic bw(input logic [15:0] sta, input logic [15:0] w);
		req(8'h00, 8'h10, sta, 8'h01, 8'h02, w, 9'h000);
	endtask : bw
	task automatic t_bcast;
		local_op_word = 16'h8FCC;
		bw(`MCC_REG_RUN_CTRL, 16'h7033);
		@(posedge sys_clk) #1;
		chk(op_word_eff, 16'hFFFF);
		chk({fault_reset_cmd, ext_fault_cmd, reverse_cmd, run_cmd}, 4'hF);
		chk({multi_input_seven, multi_input_six, multi_input_five}, 3'h7);
		bw(`MCC_REG_RUN_CTRL, 16'h0001);
		local_op_word = 16'h0000;
		repeat (2) @(posedge sys_clk);
		#1 chk(op_word_eff, 16'h0001);
		ce = 1'b0;
		local_op_word = 16'h0F00;
		repeat (2) @(posedge sys_clk);
		#1 chk(op_word_eff, 16'h0001);
		ce = 1'b1;
		bw(`MCC_REG_SPEED_REF, `MCC_SPEED_FULL);
		chk(speed_ref, 16'h7530);
		wr(`MCC_REG_SPEED_REF, 16'h7531, 9'h121);
		wr(`MCC_REG_SPEED_REF, 16'h1234, 9'h100);
		bw(16'h0003, 16'hBEEF);
		chk(speed_ref, 16'h1234);
	endtask : t_bcast
	task automatic t_drop;
		for (int i = 0; i < 6; i++) begin
			set_err(6'h01 << i);
			wr(`MCC_REG_SPEED_REF, 16'h0777, 9'h000);
			set_err(6'h00);
		end
		req(8'h12, 8'h10, `MCC_REG_SPEED_REF, 8'h01, 8'h02, 16'h0777, 9'h000);
		chk(speed_ref, 16'h1234);
	endtask : t_drop
	task automatic t_codes;
		logic [7:0] bad [4] = '{8'h01, 8'h06, 8'h0F, 8'h7F};
		for (int i = 0; i < 4; i++) begin
			req(8'h11, bad[i], 16'h0100, 8'h01, 8'h02, 16'h0000, 9'h101);
		end
		req(8'h11, 8'h08, 16'h0000, 8'h01, 8'h02, 16'h0000, 9'h100);
		req(8'h11, 8'h03, 16'h0100, 8'h00, 8'h00, 16'h0000, 9'h103);
		req(8'h11, 8'h03, 16'h0100, 8'h11, 8'h00, 16'h0000, 9'h103);
		req(8'h11, 8'h10, 16'h0100, 8'h01, 8'h03, 16'h0000, 9'h103);
		req(8'h11, 8'h03, 16'h0100, 8'h10, 8'h00, 16'h0000, 9'h100);
		chk(read_req, 1'b1);
		reg_exists = 1'b0;
		req(8'h11, 8'h03, 16'h0100, 8'h01, 8'h00, 16'h0000, 9'h102);
		reg_exists = 1'b1;
		req(8'h11, 8'h03, `MCC_REG_COMMIT_NV, 8'h01, 8'h00, 16'h0000, 9'h102);
		req(8'h11, 8'h03, `MCC_REG_COMMIT_RAM, 8'h01, 8'h00, 16'h0000, 9'h102);
	endtask : t_codes
	task automatic t_stage;
		wr(16'h0100, 16'hABCD, 9'h100);
		chk({commit_nv_pulse, commit_ram_pulse, stage_count}, 7'h01);
		chk(stage_data, 16'hABCD);
		chk(stage_base, 16'h0100);
		wr(`MCC_REG_COMMIT_RAM, 16'h0000, 9'h100);
		chk({commit_nv_pulse, commit_ram_pulse, stage_count}, 7'h20);
		wr(16'h0100, 16'h5A5A, 9'h100);
		wr(`MCC_REG_COMMIT_NV, 16'h0000, 9'h100);
		chk({commit_nv_pulse, commit_ram_pulse, stage_count}, 7'h40);
		wr(`MCC_REG_COMMIT_NV, 16'h0005, 9'h121);
		req(8'h11, 8'h10, `MCC_REG_COMMIT_NV, 8'h02, 8'h04, 16'h0000, 9'h103);
	endtask : t_stage
	task automatic t_param;
		logic [7:0] f [7] = '{8'h70, 8'h10, 8'h20, 8'h38, 8'h34, 8'h32, 8'h31};
		logic [7:0] c [7] = '{8'h22, 8'h21, 8'h21, 8'h22, 8'h23, 8'h22, 8'h24};
		for (int i = 0; i < 7; i++) begin
			set_st(f[i]);
			wr(16'h0100, 16'h0001, {1'b1, c[i]});
		end
		set_st(8'hB2);
		wr(16'h0100, 16'h0001, 9'h100);
		set_st(8'h38);
		wr(`MCC_REG_COMMIT_NV, 16'h0000, 9'h122);
		set_st(8'h34);
		wr(`MCC_REG_COMMIT_RAM, 16'h0000, 9'h123);
		set_st(8'h30);
	endtask : t_param
	task automatic wait_for_test;
		for (int i = 0; i < 400 && show_speed_ref !== 1'b1 && comm_error_alarm !== 1'b1; i++) begin
			@(posedge sys_clk) #1;
		end
	endtask : wait_for_test
	task automatic t_selftest;
		input_seven_function_select = `MCC_TEST_SEL;
		do_reset;
		wait_for_test;
		chk({test_mode, show_speed_ref, operation_ready, fault_output}, 4'hE);
		corrupt = 1'b1;
		slow = 1'b0;
		do_reset;
		wait_for_test;
		chk({comm_error_alarm, fault_output, operation_ready}, 3'h6);
		corrupt = 1'b0;
		input_seven_function_select = 8'h00;
		do_reset;
		chk({test_mode, operation_ready}, 2'h1);
	endtask : t_selftest
	// Main sequence, all inputs given a value at time zero
	initial begin
		{frame_word_data, frame_start_addr, local_op_word} = 48'h0;
		{frame_slave_addr, frame_func, frame_word_count, frame_byte_count} = 32'h0;
		set_err(6'h00);
		set_st(8'h30);
		reg_exists = 1'b1;
		slow = 1'b1;
		corrupt = 1'b0;
		do_reset;
		chk({operation_ready, test_mode, tx_valid, resp_valid}, 4'h8);
		t_bcast;
		t_drop;
		t_codes;
		t_stage;
		t_param;
		t_selftest;
		close_out;
	end
endmodule : mcc_command_checker_tb_top
